// ==== rtl/pfc_pkg.sv ====
/*
 Constants for the per-function command register bank: offsets, field
 positions, masks, reset values and the bus command used for writes.
 Assumes a configuration access port that is synchronous to the clock.
*/
package pfc_pkg;
	// ==========================================================
	// Sizes
	localparam int NUM_FUNC = 3;
	localparam int FUNC_W = 2;
	localparam int REG_W = 16;
	localparam int OFFSET_W = 8;
	localparam int BE_W = 2;
	localparam int BYTE_W = 8;
	localparam int PALETTE_W = 32;
	localparam int CMD_W = 4;

	// ==========================================================
	// Register map
	localparam logic [OFFSET_W-1:0] BUS_INTERFACE_CONTROL_OFFSET = 8'h04;
	localparam logic [REG_W-1:0] BUS_INTERFACE_CONTROL_RESET = 16'h0000;
	// Writable bits: 10, 8, 6, 5, 2, 1, 0
	localparam logic [REG_W-1:0] BUS_INTERFACE_CONTROL_WMASK = 16'h0567;

	// ==========================================================
	// Field positions
	localparam int IO_SPACE_ENABLE_BIT = 0;
	localparam int MEMORY_SPACE_ENABLE_BIT = 1;
	localparam int INITIATOR_ENABLE_BIT = 2;
	localparam int BROADCAST_CYCLE_ENABLE_BIT = 3;
	localparam int WRITE_INVALIDATE_ENABLE_BIT = 4;
	localparam int PALETTE_SNOOP_ENABLE_BIT = 5;
	localparam int PARITY_RESPONSE_ENABLE_BIT = 6;
	localparam int SYSTEM_ERROR_ENABLE_BIT = 8;
	localparam int BACK_TO_BACK_ENABLE_BIT = 9;
	localparam int LEGACY_INTERRUPT_INHIBIT_BIT = 10;

	// ==========================================================
	// Bus commands
	localparam logic [CMD_W-1:0] CMD_MEMORY_WRITE = 4'h7;
	localparam logic [CMD_W-1:0] CMD_IDLE = 4'h0;
endpackage

// ==== rtl/pfc_cmd_reg.sv ====
/*
 One function's command register: byte-lane writes through a mask,
 and the readback with locked bits forced to zero.
 Assumes write strobes are one-cycle pulses on the system clock.
*/
`timescale 1ns/1ns
module pfc_cmd_reg
(
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic wr_in,
	input wire logic [pfc_pkg::BE_W-1:0] byte_en_in,
	input wire logic [pfc_pkg::REG_W-1:0] wdata_in,
	input wire logic rev23_features_enable_in,
	output logic [pfc_pkg::REG_W-1:0] value_out
);
	logic [pfc_pkg::REG_W-1:0] cmd;
	logic [pfc_pkg::REG_W-1:0] lane_mask;
	logic [pfc_pkg::REG_W-1:0] wmask;

	// ==========================================================
	// Write mask
	always_comb
	begin
		lane_mask = {{pfc_pkg::BYTE_W{byte_en_in[1]}}, {pfc_pkg::BYTE_W{byte_en_in[0]}}};
		wmask = lane_mask & pfc_pkg::BUS_INTERFACE_CONTROL_WMASK;
	end

	// ==========================================================
	// Storage
	always_ff @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			cmd <= pfc_pkg::BUS_INTERFACE_CONTROL_RESET;
		end
		else
		begin
			if (wr_in)
			begin
				cmd <= (cmd & ~wmask) | (wdata_in & wmask);
			end
			// Locked inhibit must not come back set when features return
			if (!rev23_features_enable_in)
			begin
				cmd[pfc_pkg::LEGACY_INTERRUPT_INHIBIT_BIT] <= 1'h0;
			end
		end
	end

	always_comb
	begin
		value_out = cmd & pfc_pkg::BUS_INTERFACE_CONTROL_WMASK;
		if (!rev23_features_enable_in)
		begin
			value_out[pfc_pkg::LEGACY_INTERRUPT_INHIBIT_BIT] = 1'h0;
		end
	end
endmodule

// ==== rtl/pfc_bank.sv ====
/*
 Command register bank for three bus functions and the gating that the
 enable bits apply to claims, initiator requests, interrupts and parity.
 Assumes all inputs are synchronous to CLK_SYS_IN; the bus interface logic
 outside decodes cycles and resolves open-drain pins from the enables.
*/
`timescale 1ns/1ns
module pfc_bank
(
	input wire logic CLK_SYS_IN,
	input wire logic RESET_IN,
	// Configuration access
	input wire logic CFG_WR_IN,
	input wire logic CFG_RD_IN,
	input wire logic [pfc_pkg::FUNC_W-1:0] CFG_FUNC_IN,
	input wire logic [pfc_pkg::OFFSET_W-1:0] CFG_OFFSET_IN,
	input wire logic [pfc_pkg::BE_W-1:0] CFG_BYTE_EN_IN,
	input wire logic [pfc_pkg::REG_W-1:0] CFG_WDATA_IN,
	output logic [pfc_pkg::REG_W-1:0] CFG_RDATA_OUT,
	output logic CFG_ACK_OUT,
	output logic CFG_HIT_OUT,
	// General control feature bit
	input wire logic REV23_FEATURES_ENABLE_IN,
	// Target decode
	input wire logic [pfc_pkg::NUM_FUNC-1:0] MEM_DECODE_IN,
	input wire logic [pfc_pkg::NUM_FUNC-1:0] IO_DECODE_IN,
	input wire logic [pfc_pkg::NUM_FUNC-1:0] PALETTE_WR_IN,
	input wire logic [pfc_pkg::PALETTE_W-1:0] PALETTE_DATA_IN,
	input wire logic SPECIAL_CYCLE_IN,
	output logic [pfc_pkg::NUM_FUNC-1:0] MEM_CLAIM_OUT,
	output logic [pfc_pkg::NUM_FUNC-1:0] IO_CLAIM_OUT,
	output logic [pfc_pkg::NUM_FUNC-1:0] PALETTE_SNOOP_VALID_OUT,
	output logic [pfc_pkg::PALETTE_W-1:0] PALETTE_SNOOP_DATA_OUT,
	// Initiator
	input wire logic [pfc_pkg::NUM_FUNC-1:0] INIT_REQ_IN,
	input wire logic [pfc_pkg::NUM_FUNC-1:0] INIT_WRITE_IN,
	input wire logic BUS_GNT_N_IN,
	output logic BUS_REQ_N_OUT,
	output logic [pfc_pkg::NUM_FUNC-1:0] INIT_GO_OUT,
	output logic [pfc_pkg::CMD_W-1:0] INIT_CMD_OUT,
	// Interrupts
	input wire logic [pfc_pkg::NUM_FUNC-1:0] INT_REQ_IN,
	output logic [pfc_pkg::NUM_FUNC-1:0] INT_ASSERT_OUT,
	// Parity
	input wire logic ADDR_PAR_ERR_IN,
	input wire logic DATA_PAR_ERR_IN,
	output logic SERR_N_OUT,
	output logic SERR_OE_OUT,
	output logic PERR_N_OUT,
	output logic PERR_OE_OUT,
	output logic SERR_EVENT_OUT
);
	logic [pfc_pkg::REG_W-1:0] reg_value [pfc_pkg::NUM_FUNC];
	logic [pfc_pkg::NUM_FUNC-1:0] func_wr;
	logic [pfc_pkg::NUM_FUNC-1:0] io_en;
	logic [pfc_pkg::NUM_FUNC-1:0] mem_en;
	logic [pfc_pkg::NUM_FUNC-1:0] init_en;
	logic [pfc_pkg::NUM_FUNC-1:0] snoop_en;
	logic [pfc_pkg::NUM_FUNC-1:0] par_en;
	logic [pfc_pkg::NUM_FUNC-1:0] system_error_enable;
	logic [pfc_pkg::NUM_FUNC-1:0] int_inhibit;
	logic func_valid;
	logic offset_hit;
	logic par_any;
	logic serr_any;
	logic [pfc_pkg::NUM_FUNC-1:0] init_allowed;
	logic [pfc_pkg::NUM_FUNC-1:0] palette_capture;
	logic [pfc_pkg::REG_W-1:0] next_rdata;
	logic next_serr;
	logic next_perr;
	logic [pfc_pkg::CMD_W-1:0] next_cmd;

	// ==========================================================
	// Configuration decode
	always_comb
	begin
		func_valid = (CFG_FUNC_IN < pfc_pkg::FUNC_W'(pfc_pkg::NUM_FUNC));
	end

	// Only one offset is mapped in each function's space
	always_comb
	begin
		offset_hit = (CFG_OFFSET_IN == pfc_pkg::BUS_INTERFACE_CONTROL_OFFSET);
	end

	// ==========================================================
	// Per-function registers and their enables
	generate
		for (genvar f = 0; f < pfc_pkg::NUM_FUNC; f++)
		begin : g_func
			// Each function decodes its own write strobe
			assign func_wr[f] = CFG_WR_IN && func_valid && offset_hit
				&& (CFG_FUNC_IN == pfc_pkg::FUNC_W'(f));

			pfc_cmd_reg u_reg
			(
				.clk_in(CLK_SYS_IN),
				.reset_in(RESET_IN),
				.wr_in(func_wr[f]),
				.byte_en_in(CFG_BYTE_EN_IN),
				.wdata_in(CFG_WDATA_IN),
				.rev23_features_enable_in(REV23_FEATURES_ENABLE_IN),
				.value_out(reg_value[f])
			);

			assign io_en[f] = reg_value[f][pfc_pkg::IO_SPACE_ENABLE_BIT];
			assign mem_en[f] = reg_value[f][pfc_pkg::MEMORY_SPACE_ENABLE_BIT];
			assign init_en[f] = reg_value[f][pfc_pkg::INITIATOR_ENABLE_BIT];
			assign snoop_en[f] = reg_value[f][pfc_pkg::PALETTE_SNOOP_ENABLE_BIT];
			assign par_en[f] = reg_value[f][pfc_pkg::PARITY_RESPONSE_ENABLE_BIT];
			assign system_error_enable[f] = reg_value[f][pfc_pkg::SYSTEM_ERROR_ENABLE_BIT];
			assign int_inhibit[f] = reg_value[f][pfc_pkg::LEGACY_INTERRUPT_INHIBIT_BIT];

			// Palette writes are I/O cycles; a snooping function lets another agent answer
			assign palette_capture[f] = PALETTE_WR_IN[f] && snoop_en[f];

			always_comb
			begin
				MEM_CLAIM_OUT[f] = MEM_DECODE_IN[f] && mem_en[f] && !SPECIAL_CYCLE_IN;
			end

			// Special cycles are never claimed, whatever the decode says
			always_comb
			begin
				IO_CLAIM_OUT[f] = IO_DECODE_IN[f] && io_en[f] && !SPECIAL_CYCLE_IN
					&& !palette_capture[f];
			end

			// Interrupt gating is combinational so inhibit acts at once
			assign INT_ASSERT_OUT[f] = INT_REQ_IN[f] && !int_inhibit[f];

			assign init_allowed[f] = INIT_REQ_IN[f] && init_en[f];
		end
	endgenerate

	// ==========================================================
	// Enables shared by the whole device
	always_comb
	begin
		par_any = |par_en;
	end

	// Wired OR: each function still reads back only its own copy
	always_comb
	begin
		serr_any = |system_error_enable;
	end

	// ==========================================================
	// Configuration readback
	always_comb
	begin
		next_rdata = '0;
		if (func_valid && offset_hit)
		begin
			// Reserved and hardwired bits are already zero in the register value
			next_rdata = reg_value[CFG_FUNC_IN];
		end
	end

	// Read data holds until the next read, so the host may sample it late
	always_ff @(posedge CLK_SYS_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
		begin
			CFG_RDATA_OUT <= pfc_pkg::BUS_INTERFACE_CONTROL_RESET;
		end
		else if (CFG_RD_IN)
		begin
			CFG_RDATA_OUT <= next_rdata;
		end
	end

	// One acknowledge per access, unmapped offsets included, so no cycle hangs
	always_ff @(posedge CLK_SYS_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
		begin
			CFG_ACK_OUT <= 1'h0;
		end
		else
		begin
			CFG_ACK_OUT <= CFG_RD_IN || CFG_WR_IN;
		end
	end

	// Hit tells the host whether the access reached a real register
	always_ff @(posedge CLK_SYS_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
		begin
			CFG_HIT_OUT <= 1'h0;
		end
		else
		begin
			CFG_HIT_OUT <= (CFG_RD_IN || CFG_WR_IN) && func_valid && offset_hit;
		end
	end

	// ==========================================================
	// Palette snoop capture
	always_ff @(posedge CLK_SYS_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
		begin
			PALETTE_SNOOP_DATA_OUT <= '0;
		end
		else if (|palette_capture)
		begin
			PALETTE_SNOOP_DATA_OUT <= PALETTE_DATA_IN;
		end
	end

	// One pulse per captured write; the data alone cannot show a repeat
	always_ff @(posedge CLK_SYS_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
		begin
			PALETTE_SNOOP_VALID_OUT <= '0;
		end
		else
		begin
			PALETTE_SNOOP_VALID_OUT <= palette_capture;
		end
	end

	// ==========================================================
	// Initiator
	// Request is registered to meet bus timing; grant is passed on combinationally
	always_ff @(posedge CLK_SYS_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
		begin
			BUS_REQ_N_OUT <= 1'h1;
		end
		else
		begin
			BUS_REQ_N_OUT <= !(|init_allowed);
		end
	end

	always_comb
	begin
		INIT_GO_OUT = init_allowed & {pfc_pkg::NUM_FUNC{!BUS_GNT_N_IN && !BUS_REQ_N_OUT}};
	end

	// Write-and-invalidate is never offered, so every write goes out as a plain write
	always_comb
	begin
		next_cmd = pfc_pkg::CMD_IDLE;
		if (|(init_allowed & INIT_WRITE_IN))
		begin
			next_cmd = pfc_pkg::CMD_MEMORY_WRITE;
		end
	end

	// Registered so the command lines up with the registered request
	always_ff @(posedge CLK_SYS_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
		begin
			INIT_CMD_OUT <= pfc_pkg::CMD_IDLE;
		end
		else
		begin
			INIT_CMD_OUT <= next_cmd;
		end
	end

	// ==========================================================
	// Parity error reporting
	always_comb
	begin
		next_serr = ADDR_PAR_ERR_IN && serr_any && par_any;
		next_perr = DATA_PAR_ERR_IN && par_any;
	end

	// Open-drain pins: the value is low only while enabled, pulled high otherwise
	always_ff @(posedge CLK_SYS_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
		begin
			SERR_OE_OUT <= 1'h0;
		end
		else
		begin
			SERR_OE_OUT <= next_serr;
		end
	end

	always_ff @(posedge CLK_SYS_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
		begin
			SERR_N_OUT <= 1'h1;
		end
		else
		begin
			SERR_N_OUT <= !next_serr;
		end
	end

	// Event pulse lets the status logic outside record a signalled error
	always_ff @(posedge CLK_SYS_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
		begin
			SERR_EVENT_OUT <= 1'h0;
		end
		else
		begin
			SERR_EVENT_OUT <= next_serr;
		end
	end

	// Limitation: PERR is one cycle wide; sustaining it is left to the pin logic
	always_ff @(posedge CLK_SYS_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
		begin
			PERR_OE_OUT <= 1'h0;
		end
		else
		begin
			PERR_OE_OUT <= next_perr;
		end
	end

	always_ff @(posedge CLK_SYS_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
		begin
			PERR_N_OUT <= 1'h1;
		end
		else
		begin
			PERR_N_OUT <= !next_perr;
		end
	end
endmodule

// ==== tb/pfc_host.sv ====
/*
 Host-side arbiter model: grants the bus after a programmable wait.
 Assumes the bank's request is registered on the same clock.
*/
`timescale 1ns/1ns
module pfc_host
(
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic req_n_in,
	input wire logic [3:0] delay_in,
	output logic gnt_n_out
);
	logic [3:0] wait_cnt;
	// ==========================================
	// Grant
	always_ff @(posedge clk_in or posedge reset_in)
		if (reset_in)
			wait_cnt <= 4'h0;
		else if (req_n_in)
			wait_cnt <= 4'h0;
		else if (wait_cnt != delay_in)
			wait_cnt <= wait_cnt + 4'h1;
	// Withdrawn at once with the request, as a real arbiter may
	assign gnt_n_out = req_n_in || (wait_cnt != delay_in);
endmodule

// ==== tb/pfc_chk_chk.sv ====
/*
 Checker for the command register bank, bound to each bank.
 Sees only the bank's ports; one clock domain.
*/
`timescale 1ns/1ns
module pfc_chk
(
	input wire logic CLK_SYS_IN,
	input wire logic RESET_IN,
	input wire logic CFG_WR_IN,
	input wire logic CFG_RD_IN,
	input wire logic CFG_ACK_OUT,
	input wire logic REV23_FEATURES_ENABLE_IN,
	input wire logic SPECIAL_CYCLE_IN,
	input wire logic [2:0] MEM_DECODE_IN,
	input wire logic [2:0] IO_DECODE_IN,
	input wire logic [2:0] MEM_CLAIM_OUT,
	input wire logic [2:0] IO_CLAIM_OUT,
	input wire logic [2:0] INT_REQ_IN,
	input wire logic [2:0] INT_ASSERT_OUT,
	input wire logic [2:0] INIT_REQ_IN,
	input wire logic [2:0] INIT_GO_OUT,
	input wire logic BUS_GNT_N_IN,
	input wire logic BUS_REQ_N_OUT,
	input wire logic ADDR_PAR_ERR_IN,
	input wire logic DATA_PAR_ERR_IN,
	input wire logic SERR_N_OUT,
	input wire logic SERR_OE_OUT,
	input wire logic PERR_N_OUT,
	input wire logic PERR_OE_OUT
);
	default clocking cb @(posedge CLK_SYS_IN);
	endclocking
	default disable iff (RESET_IN);
	// ==========================================
	// Properties
	property p_ack; (CFG_WR_IN || CFG_RD_IN) |=> CFG_ACK_OUT; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_mem; (MEM_CLAIM_OUT & ~(MEM_DECODE_IN & {3{!SPECIAL_CYCLE_IN}})) == 3'h0; endproperty
	a_mem: assert property (p_mem) else $error("bad mem claim");
	property p_io; (IO_CLAIM_OUT & ~(IO_DECODE_IN & {3{!SPECIAL_CYCLE_IN}})) == 3'h0; endproperty
	a_io: assert property (p_io) else $error("bad io claim");
	property p_int;
		(INT_ASSERT_OUT & ~INT_REQ_IN) == 3'h0 &&
		(REV23_FEATURES_ENABLE_IN || INT_ASSERT_OUT == INT_REQ_IN);
	endproperty
	a_int: assert property (p_int) else $error("bad interrupt");
	property p_serr; SERR_OE_OUT |-> $past(ADDR_PAR_ERR_IN) && !SERR_N_OUT; endproperty
	a_serr: assert property (p_serr) else $error("bad serr");
	property p_perr; PERR_OE_OUT |-> $past(DATA_PAR_ERR_IN) && !PERR_N_OUT; endproperty
	a_perr: assert property (p_perr) else $error("bad perr");
	property p_go;
		INIT_GO_OUT != 3'h0 |->
		!BUS_GNT_N_IN && !BUS_REQ_N_OUT && (INIT_GO_OUT & ~INIT_REQ_IN) == 3'h0;
	endproperty
	a_go: assert property (p_go) else $error("bad go");
	property p_req; $fell(BUS_REQ_N_OUT) |-> $past(INIT_REQ_IN) != 3'h0; endproperty
	a_req: assert property (p_req) else $error("bad request");
endmodule
bind pfc_bank pfc_chk chk (.*);

// ==== tb/testbench.sv ====
/*
 Bench for the command register bank: config accesses, claims, parity
 and initiator. Assumes the host model and the bound checker.
*/
`timescale 1ns/1ns
module testbench;
	logic CLK_SYS_IN = 1'h0, RESET_IN = 1'h1, CFG_WR_IN = 1'h0, CFG_RD_IN = 1'h0;
	logic [1:0] CFG_FUNC_IN = '0, CFG_BYTE_EN_IN = 2'h3;
	logic [7:0] CFG_OFFSET_IN = 8'h04;
	logic [15:0] CFG_WDATA_IN = '0, CFG_RDATA_OUT;
	logic CFG_ACK_OUT, CFG_HIT_OUT, REV23_FEATURES_ENABLE_IN = 1'h1, SPECIAL_CYCLE_IN = 1'h0;
	logic [2:0] MEM_DECODE_IN = '0, IO_DECODE_IN = '0, PALETTE_WR_IN = '0, INIT_REQ_IN = '0;
	logic [2:0] INIT_WRITE_IN = '0, INT_REQ_IN = '0, MEM_CLAIM_OUT, IO_CLAIM_OUT, INIT_GO_OUT;
	logic [2:0] PALETTE_SNOOP_VALID_OUT, INT_ASSERT_OUT;
	logic [31:0] PALETTE_DATA_IN = '0, PALETTE_SNOOP_DATA_OUT;
	logic [3:0] INIT_CMD_OUT, gnt_delay = 4'h0;
	logic BUS_GNT_N_IN, BUS_REQ_N_OUT, ADDR_PAR_ERR_IN = 1'h0, DATA_PAR_ERR_IN = 1'h0;
	logic SERR_N_OUT, SERR_OE_OUT, PERR_N_OUT, PERR_OE_OUT, SERR_EVENT_OUT;
	int n_fail = 0, n_checks = 0, cyc = 0, tn = 0;
	pfc_bank dut (.*);
	pfc_host host (.clk_in(CLK_SYS_IN), .reset_in(RESET_IN), .req_n_in(BUS_REQ_N_OUT),
		.delay_in(gnt_delay), .gnt_n_out(BUS_GNT_N_IN));
	always #5 CLK_SYS_IN = !CLK_SYS_IN;
	// ==========================================
	// Tasks
	task final_report;
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge CLK_SYS_IN)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			n_fail++;
			final_report;
		end
	end
	task check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task tend;
		tn++;
		$display("test %0d done", tn);
	endtask
	task acc(input logic wr, input logic [1:0] f, input logic [15:0] d);
		@(posedge CLK_SYS_IN);
		CFG_WR_IN <= wr;
		CFG_RD_IN <= !wr;
		CFG_FUNC_IN <= f;
		CFG_WDATA_IN <= d;
		@(posedge CLK_SYS_IN);
		CFG_WR_IN <= 1'h0;
		CFG_RD_IN <= 1'h0;
		#1;
		check(CFG_ACK_OUT, 1'h1);
		check(CFG_HIT_OUT, f != 2'h3 && CFG_OFFSET_IN == 8'h04);
	endtask
	task rd(input logic [1:0] f, input logic [15:0] e);
		acc(1'h0, f, 16'h0000);
		check(CFG_RDATA_OUT, e);
	endtask
	task set3(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
		acc(1'h1, 2'h0, a);
		acc(1'h1, 2'h1, b);
		acc(1'h1, 2'h2, c);
	endtask
	task par(input logic a, input logic d, input logic [1:0] e);
		@(posedge CLK_SYS_IN);
		ADDR_PAR_ERR_IN <= a;
		DATA_PAR_ERR_IN <= d;
		@(posedge CLK_SYS_IN);
		ADDR_PAR_ERR_IN <= 1'h0;
		DATA_PAR_ERR_IN <= 1'h0;
		#1;
		check({SERR_OE_OUT, PERR_OE_OUT}, e);
		check({SERR_N_OUT, PERR_N_OUT}, {!e[1], !e[0]});
		check(SERR_EVENT_OUT, e[1]);
	endtask
	task init(input logic [3:0] d);
		@(posedge CLK_SYS_IN);
		gnt_delay <= d;
		INIT_REQ_IN <= 3'h2;
		INIT_WRITE_IN <= 3'h2;
		for (int i = 0; i < 20 && INIT_GO_OUT !== 3'h2; i++)
			@(posedge CLK_SYS_IN) #1;
		check(INIT_GO_OUT, 3'h2);
		check(INIT_CMD_OUT, pfc_pkg::CMD_MEMORY_WRITE);
		@(posedge CLK_SYS_IN);
		INIT_REQ_IN <= 3'h0;
	endtask
	// ==========================================
	// Tests
	initial
	begin
		repeat (2) @(posedge CLK_SYS_IN);
		RESET_IN <= 1'h0;
		for (logic [1:0] f = 2'h0; f != 2'h3; f++)
			rd(f, pfc_pkg::BUS_INTERFACE_CONTROL_RESET);
		tend;
		set3(16'hFFFF, 16'h0000, 16'h0001);
		rd(2'h0, 16'h0567);
		rd(2'h1, 16'h0000);
		rd(2'h2, 16'h0001);
		@(posedge CLK_SYS_IN) INT_REQ_IN <= 3'h7;
		#1 check(INT_ASSERT_OUT, 3'h6);
		@(posedge CLK_SYS_IN) REV23_FEATURES_ENABLE_IN <= 1'h0;
		#1 check(INT_ASSERT_OUT, 3'h7);
		acc(1'h1, 2'h0, 16'hFFFF);
		rd(2'h0, 16'h0167);
		@(posedge CLK_SYS_IN) REV23_FEATURES_ENABLE_IN <= 1'h1;
		rd(2'h0, 16'h0167);
		tend;
		@(posedge CLK_SYS_IN) CFG_BYTE_EN_IN <= 2'h1;
		acc(1'h1, 2'h1, 16'hFFFF);
		@(posedge CLK_SYS_IN) CFG_BYTE_EN_IN <= 2'h3;
		rd(2'h1, 16'h0067);
		acc(1'h1, 2'h3, 16'hFFFF);
		rd(2'h3, 16'h0000);
		check(CFG_HIT_OUT, 1'h0);
		@(posedge CLK_SYS_IN) CFG_OFFSET_IN <= 8'h08;
		rd(2'h0, 16'h0000);
		@(posedge CLK_SYS_IN) CFG_OFFSET_IN <= 8'h04;
		tend;
		set3(16'h0003, 16'h0000, 16'h0021);
		@(posedge CLK_SYS_IN) MEM_DECODE_IN <= 3'h7;
		IO_DECODE_IN <= 3'h7;
		#1 check({MEM_CLAIM_OUT, IO_CLAIM_OUT}, 6'h0D);
		@(posedge CLK_SYS_IN) SPECIAL_CYCLE_IN <= 1'h1;
		#1 check({MEM_CLAIM_OUT, IO_CLAIM_OUT}, 6'h00);
		@(posedge CLK_SYS_IN) SPECIAL_CYCLE_IN <= 1'h0;
		PALETTE_WR_IN <= 3'h5;
		PALETTE_DATA_IN <= 32'hA5C3_0F18;
		#1 check(IO_CLAIM_OUT, 3'h1);
		@(posedge CLK_SYS_IN) PALETTE_WR_IN <= 3'h0;
		#1 check(PALETTE_SNOOP_VALID_OUT, 3'h4);
		check(PALETTE_SNOOP_DATA_OUT, 32'hA5C3_0F18);
		tend;
		set3(16'h0100, 16'h0040, 16'h0000);
		par(1'h1, 1'h1, 2'h3);
		acc(1'h1, 2'h1, 16'h0000);
		par(1'h1, 1'h1, 2'h0);
		set3(16'h0000, 16'h0040, 16'h0000);
		par(1'h1, 1'h1, 2'h1);
		tend;
		set3(16'h0000, 16'h0004, 16'h0000);
		init(4'h0);
		init(4'h5);
		@(posedge CLK_SYS_IN) INIT_REQ_IN <= 3'h1;
		repeat (3) @(posedge CLK_SYS_IN);
		#1 check({BUS_REQ_N_OUT, INIT_GO_OUT}, 4'h8);
		check(INIT_CMD_OUT, pfc_pkg::CMD_IDLE);
		tend;
		@(posedge CLK_SYS_IN) RESET_IN <= 1'h1;
		@(posedge CLK_SYS_IN) RESET_IN <= 1'h0;
		rd(2'h1, 16'h0000);
		tend;
		final_report;
	end
endmodule
